/* verilog/sim_defs.svh */
// register map, field positions and reset values of the serial controller interrupt mask block
// assumes a 32-bit word register port with byte addresses
`ifndef SIM_DEFS_SVH
`define SIM_DEFS_SVH
`define SIM_OFF_STATUS      8'h00
`define SIM_OFF_ENABLE_SET  8'h04
`define SIM_OFF_ENABLE_CLR  8'h08
`define SIM_OFF_MASK_VIEW   8'h0c
`define SIM_OFF_HOLD        8'h10
`define SIM_NUM_EVENTS      12
`define SIM_BIT_TX_FREE     0
`define SIM_BIT_TX_SENT     1
`define SIM_BIT_TX_DONE     2
`define SIM_BIT_TX_ZERO     3
`define SIM_BIT_RX_AVAIL    4
`define SIM_BIT_OVERRUN     5
`define SIM_BIT_RX_DONE     6
`define SIM_BIT_RX_ZERO     7
`define SIM_BIT_CMP_A       8
`define SIM_BIT_CMP_B       9
`define SIM_BIT_TX_SYNC     10
`define SIM_BIT_RX_SYNC     11
`define SIM_MASK_RESET      12'h000
`define SIM_STICKY_MASK     12'hf00
`endif

/* verilog/sim_pkg.sv */
// types of the serial controller interrupt mask block
// assumes sim_defs.svh for widths
`include "sim_defs.svh"
package sim_pkg;
    typedef logic [`SIM_NUM_EVENTS-1:0] sim_evt_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } sim_bus_req_t;
    // level sources from the datapath plus event pulses
    typedef struct packed {
        logic tx_holding_free;
        logic tx_all_sent;
        logic tx_count_done;
        logic tx_counters_zero;
        logic rx_word_available;
        logic rx_count_done;
        logic rx_counters_zero;
        logic rx_load;
        logic compare_match_a;
        logic compare_match_b;
        logic tx_sync_seen;
        logic rx_sync_seen;
    } sim_src_t;
endpackage

/* verilog/sim_irq_mask.sv */
// interrupt enable, disable and mask logic with event status of a synchronous serial controller
// assumes status sources come from logic on clk; register port per house bus, read data one cycle later
//
// Functional notes
// - Writing a one to a bit of the disable register clears that mask bit, zeros leave it alone.
// - Writing a one to a bit of the enable register sets that mask bit, zeros leave it alone.
// - The read-only mask view reads one for each enabled event interrupt and zero otherwise.
// - Bits 0 to 7 are tx ready, tx empty, end of tx, tx buffer empty, rx ready, overrun, end of rx, rx buffer full.
// - Bits 8 to 11 are compare a, compare b, tx sync and rx sync, and bits 12 to 31 read zero.
// - Each compare match event has its own independently controlled mask bit.
// - Transmit and receive sync events each have their own mask bit set and cleared the same way.
// - The receive buffer full event has its own mask bit, cleared by a disable write.
// - Compare and sync flags are sticky since the last status read and clear on that read.
// - Overrun sets when a new word loads while the previous one is still unread, and clears on a status read.
`timescale 1ns/1ps
`include "sim_defs.svh"
module sim_irq_mask (
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    input  wire sim_pkg::sim_bus_req_t bus_req,
    output logic [31:0]                rdata,
    input  wire sim_pkg::sim_src_t     src,
    input  wire logic                  rx_word_read,
    output logic                       irq
);
    import sim_pkg::*;

    sim_evt_t mask_reg;
    sim_evt_t sticky_reg;
    logic     overrun_reg;
    logic     unread_reg;
    sim_evt_t status_now;
    sim_evt_t sticky_next;
    logic     wr_set;
    logic     wr_clr;
    logic     rd_status;

    function automatic logic hit(input logic strobe, input logic [7:0] a, input logic [7:0] off);
        hit = strobe && (a == off);
    endfunction

    assign wr_set    = hit(bus_req.wr, bus_req.addr, `SIM_OFF_ENABLE_SET);
    assign wr_clr    = hit(bus_req.wr, bus_req.addr, `SIM_OFF_ENABLE_CLR);
    assign rd_status = hit(bus_req.rd, bus_req.addr, `SIM_OFF_STATUS);

    // mask set and clear; a set and clear cannot coincide as strobes are single
    always_ff @(posedge clk) begin
        if (srst) begin
            mask_reg <= `SIM_MASK_RESET;
        end else if (ce) begin
            if (wr_set) begin
                mask_reg <= mask_reg | bus_req.wdata[`SIM_NUM_EVENTS-1:0];
            end else if (wr_clr) begin
                mask_reg <= mask_reg & ~bus_req.wdata[`SIM_NUM_EVENTS-1:0];
            end
        end
    end

    // sticky compare and sync flags, new event wins over the read clear
    always_comb begin
        sticky_next = rd_status ? '0 : sticky_reg;
        sticky_next[`SIM_BIT_CMP_A] = sticky_next[`SIM_BIT_CMP_A] | src.compare_match_a;
        sticky_next[`SIM_BIT_CMP_B] = sticky_next[`SIM_BIT_CMP_B] | src.compare_match_b;
        sticky_next[`SIM_BIT_TX_SYNC] = sticky_next[`SIM_BIT_TX_SYNC] | src.tx_sync_seen;
        sticky_next[`SIM_BIT_RX_SYNC] = sticky_next[`SIM_BIT_RX_SYNC] | src.rx_sync_seen;
        sticky_next = sticky_next & `SIM_STICKY_MASK;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sticky_reg <= '0;
        end else if (ce) begin
            sticky_reg <= sticky_next;
        end
    end

    // unread tracks a held word not yet read; overrun when a load finds it unread
    always_ff @(posedge clk) begin
        if (srst) begin
            unread_reg <= 1'b0;
        end else if (ce) begin
            if (src.rx_load) begin
                unread_reg <= 1'b1;
            end else if (rx_word_read) begin
                unread_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            overrun_reg <= 1'b0;
        end else if (ce) begin
            if (src.rx_load && unread_reg && !rx_word_read) begin
                overrun_reg <= 1'b1;
            end else if (rd_status) begin
                overrun_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        status_now = sticky_reg;
        status_now[`SIM_BIT_TX_FREE]  = src.tx_holding_free;
        status_now[`SIM_BIT_TX_SENT]  = src.tx_all_sent;
        status_now[`SIM_BIT_TX_DONE]  = src.tx_count_done;
        status_now[`SIM_BIT_TX_ZERO]  = src.tx_counters_zero;
        status_now[`SIM_BIT_RX_AVAIL] = src.rx_word_available;
        status_now[`SIM_BIT_OVERRUN]  = overrun_reg;
        status_now[`SIM_BIT_RX_DONE]  = src.rx_count_done;
        status_now[`SIM_BIT_RX_ZERO]  = src.rx_counters_zero;
    end

    // read data one cycle after the strobe, zero otherwise and for unmapped offsets
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= 32'h0000_0000;
        end else if (ce) begin
            rdata <= 32'h0000_0000;
            if (bus_req.rd) begin
                unique case (bus_req.addr)
                    `SIM_OFF_STATUS:    rdata <= {20'h00000, status_now};
                    `SIM_OFF_MASK_VIEW: rdata <= {20'h00000, mask_reg};
                    default:            rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else if (ce) begin
            irq <= |(status_now & mask_reg);
        end
    end

    property p_set;
        @(posedge clk) disable iff (srst)
        (ce && wr_set) |=> ((mask_reg & $past(bus_req.wdata[11:0])) == $past(bus_req.wdata[11:0]));
    endproperty
    a_set: assert property (p_set) else $error("enable write did not set mask");

    property p_clr;
        @(posedge clk) disable iff (srst)
        (ce && wr_clr) |=> ((mask_reg & $past(bus_req.wdata[11:0])) == 12'h000);
    endproperty
    a_clr: assert property (p_clr) else $error("disable write did not clear mask");

    property p_keep;
        @(posedge clk) disable iff (srst)
        (ce && wr_clr) |=> ((mask_reg & ~$past(bus_req.wdata[11:0]))
                            == ($past(mask_reg) & ~$past(bus_req.wdata[11:0])));
    endproperty
    a_keep: assert property (p_keep) else $error("disable write touched zero bits");

    property p_view;
        @(posedge clk) disable iff (srst)
        (ce && bus_req.rd && bus_req.addr == `SIM_OFF_MASK_VIEW) |=> (rdata == {20'h00000, $past(mask_reg)});
    endproperty
    a_view: assert property (p_view) else $error("mask view mismatch");

    sequence s_cmp_event;
        ce && src.compare_match_a;
    endsequence
    property p_sticky;
        @(posedge clk) disable iff (srst)
        s_cmp_event |=> sticky_reg[`SIM_BIT_CMP_A];
    endproperty
    a_sticky: assert property (p_sticky) else $error("compare flag lost");

    property p_rdclr;
        @(posedge clk) disable iff (srst)
        (ce && rd_status && !src.rx_sync_seen) |=> !sticky_reg[`SIM_BIT_RX_SYNC];
    endproperty
    a_rdclr: assert property (p_rdclr) else $error("sync flag not cleared by read");

    property p_ovr;
        @(posedge clk) disable iff (srst)
        (ce && src.rx_load && unread_reg && !rx_word_read) |=> overrun_reg;
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed");

    property p_irq;
        @(posedge clk) disable iff (srst)
        (ce && !srst) |=> (irq == |($past(status_now) & $past(mask_reg)));
    endproperty
    a_irq: assert property (p_irq) else $error("irq wrong");

    property p_hi;
        @(posedge clk) disable iff (srst)
        (ce && bus_req.rd) |=> (rdata[31:12] == 20'h00000);
    endproperty
    a_hi: assert property (p_hi) else $error("unused bits not zero");

    // mask write, hold, freeze and reset checks
    property p_set_keep;
        @(posedge clk) disable iff (srst)
        (ce && wr_set) |=> ((mask_reg & ~$past(bus_req.wdata[11:0]))
                            == ($past(mask_reg) & ~$past(bus_req.wdata[11:0])));
    endproperty
    a_set_keep: assert property (p_set_keep) else $error("enable write touched zero bits");

    property p_mask_hold;
        @(posedge clk) disable iff (srst)
        (ce && !srst && !wr_set && !wr_clr) |=> (mask_reg == $past(mask_reg));
    endproperty
    a_mask_hold: assert property (p_mask_hold) else $error("mask changed without a write");

    property p_freeze;
        @(posedge clk) disable iff (srst)
        (!ce && !srst) |=> ((mask_reg == $past(mask_reg)) && (rdata == $past(rdata)) && (irq == $past(irq)));
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while enable low");

    property p_rst;
        @(posedge clk)
        srst |=> ((mask_reg == `SIM_MASK_RESET) && !irq && (rdata == 32'h0000_0000));
    endproperty
    a_rst: assert property (p_rst) else $error("reset left state behind");

    // status view, sticky flag, overrun, unread, read data and irq checks
    sequence s_status_read;
        ce && rd_status;
    endsequence

    property p_map_tx_free;
        @(posedge clk) disable iff (srst)
        s_status_read |=> (rdata[`SIM_BIT_TX_FREE] == $past(src.tx_holding_free));
    endproperty
    a_map_tx_free: assert property (p_map_tx_free) else $error("tx free bit misplaced");

    property p_map_tx_sent;
        @(posedge clk) disable iff (srst)
        s_status_read |=> (rdata[`SIM_BIT_TX_SENT] == $past(src.tx_all_sent));
    endproperty
    a_map_tx_sent: assert property (p_map_tx_sent) else $error("tx sent bit misplaced");

    property p_map_tx_done;
        @(posedge clk) disable iff (srst)
        s_status_read |=> (rdata[`SIM_BIT_TX_DONE] == $past(src.tx_count_done));
    endproperty
    a_map_tx_done: assert property (p_map_tx_done) else $error("tx done bit misplaced");

    property p_map_tx_zero;
        @(posedge clk) disable iff (srst)
        s_status_read |=> (rdata[`SIM_BIT_TX_ZERO] == $past(src.tx_counters_zero));
    endproperty
    a_map_tx_zero: assert property (p_map_tx_zero) else $error("tx zero bit misplaced");

    property p_map_rx_avail;
        @(posedge clk) disable iff (srst)
        s_status_read |=> (rdata[`SIM_BIT_RX_AVAIL] == $past(src.rx_word_available));
    endproperty
    a_map_rx_avail: assert property (p_map_rx_avail) else $error("rx available bit misplaced");

    property p_map_rx_done;
        @(posedge clk) disable iff (srst)
        s_status_read |=> (rdata[`SIM_BIT_RX_DONE] == $past(src.rx_count_done));
    endproperty
    a_map_rx_done: assert property (p_map_rx_done) else $error("rx done bit misplaced");

    property p_map_rx_zero;
        @(posedge clk) disable iff (srst)
        s_status_read |=> (rdata[`SIM_BIT_RX_ZERO] == $past(src.rx_counters_zero));
    endproperty
    a_map_rx_zero: assert property (p_map_rx_zero) else $error("rx buffer full bit misplaced");

    property p_sticky_b;
        @(posedge clk) disable iff (srst)
        (ce && src.compare_match_b) |=> sticky_reg[`SIM_BIT_CMP_B];
    endproperty
    a_sticky_b: assert property (p_sticky_b) else $error("second compare flag lost");

    property p_sticky_tx;
        @(posedge clk) disable iff (srst)
        (ce && src.tx_sync_seen) |=> sticky_reg[`SIM_BIT_TX_SYNC];
    endproperty
    a_sticky_tx: assert property (p_sticky_tx) else $error("tx sync flag lost");

    property p_sticky_rx;
        @(posedge clk) disable iff (srst)
        (ce && src.rx_sync_seen) |=> sticky_reg[`SIM_BIT_RX_SYNC];
    endproperty
    a_sticky_rx: assert property (p_sticky_rx) else $error("rx sync flag lost");

    property p_rdclr_a;
        @(posedge clk) disable iff (srst)
        (ce && rd_status && !src.compare_match_a) |=> !sticky_reg[`SIM_BIT_CMP_A];
    endproperty
    a_rdclr_a: assert property (p_rdclr_a) else $error("compare flag not cleared by read");

    property p_rdclr_b;
        @(posedge clk) disable iff (srst)
        (ce && rd_status && !src.compare_match_b) |=> !sticky_reg[`SIM_BIT_CMP_B];
    endproperty
    a_rdclr_b: assert property (p_rdclr_b) else $error("second compare flag not cleared by read");

    property p_rdclr_tx;
        @(posedge clk) disable iff (srst)
        (ce && rd_status && !src.tx_sync_seen) |=> !sticky_reg[`SIM_BIT_TX_SYNC];
    endproperty
    a_rdclr_tx: assert property (p_rdclr_tx) else $error("tx sync flag not cleared by read");

    property p_sync_wins;
        @(posedge clk) disable iff (srst)
        (ce && rd_status && src.tx_sync_seen) |=> sticky_reg[`SIM_BIT_TX_SYNC];
    endproperty
    a_sync_wins: assert property (p_sync_wins) else $error("read clear beat a new sync event");

    property p_sticky_hold;
        @(posedge clk) disable iff (srst)
        (ce && !srst && !rd_status) |=> ((sticky_reg & $past(sticky_reg)) == $past(sticky_reg));
    endproperty
    a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag lost without read");

    property p_ovr_clr;
        @(posedge clk) disable iff (srst)
        (ce && rd_status && !(src.rx_load && unread_reg && !rx_word_read)) |=> !overrun_reg;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared by read");

    property p_ovr_hold;
        @(posedge clk) disable iff (srst)
        (ce && !srst && !rd_status && !(src.rx_load && unread_reg && !rx_word_read))
            |=> (overrun_reg == $past(overrun_reg));
    endproperty
    a_ovr_hold: assert property (p_ovr_hold) else $error("overrun changed without cause");

    property p_unread_set;
        @(posedge clk) disable iff (srst)
        (ce && src.rx_load) |=> unread_reg;
    endproperty
    a_unread_set: assert property (p_unread_set) else $error("loaded word not marked unread");

    property p_unread_clr;
        @(posedge clk) disable iff (srst)
        (ce && rx_word_read && !src.rx_load) |=> !unread_reg;
    endproperty
    a_unread_clr: assert property (p_unread_clr) else $error("read word still marked unread");

    property p_rd_zero;
        @(posedge clk) disable iff (srst)
        (ce && !(bus_req.rd && (bus_req.addr == `SIM_OFF_STATUS || bus_req.addr == `SIM_OFF_MASK_VIEW)))
            |=> (rdata == 32'h0000_0000);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero outside a read");

    property p_irq_masked;
        @(posedge clk) disable iff (srst)
        (ce && !srst && (mask_reg == `SIM_MASK_RESET)) |=> !irq;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq with every source masked");
endmodule

/* bench/sim_irq_mask_bench.sv */
// self-checking bench for the serial controller interrupt mask block
// assumes sim_pkg and sim_defs.svh are compiled first; one 100 MHz clock, synchronous reset
`timescale 1ns/1ps
`include "sim_defs.svh"
module sim_irq_mask_bench;
    import sim_pkg::*;
    logic         clk;
    logic         srst;
    logic         ce;
    logic         rx_word_read;
    logic         irq;
    logic [31:0]  rdata;
    logic [31:0]  d;
    sim_bus_req_t bus_req;
    sim_src_t     src;
    int           failures = 0;
    int           num_checks = 0;
    int           cycles = 0;
    // packed position inside src of the source behind each status bit
    int           pos [12] = '{11, 10, 9, 8, 7, 4, 6, 5, 3, 2, 1, 0};

    sim_irq_mask i_sim_irq_mask (.clk(clk), .srst(srst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
                                 .src(src), .rx_word_read(rx_word_read), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_irq(input logic exp, input string msg);
        num_checks++;
        if (irq !== exp) begin
            failures++;
            $display("wrong value at %0t: %s irq %b expected %b", $time, msg, irq, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk) bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk) bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk) bus_req.rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic irq_after(input logic exp, input string msg);
        repeat (2) @(posedge clk);
        #1 chk_irq(exp, msg);
    endtask

    task automatic t_reset();
        rd(`SIM_OFF_MASK_VIEW, d);
        chk(d, 32'h0, "mask after reset");
        chk_irq(1'b0, "irq after reset");
        rd(8'h20, d);
        chk(d, 32'h0, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_setclr();
        wr(`SIM_OFF_ENABLE_SET, 32'hffff_ffff);
        rd(`SIM_OFF_MASK_VIEW, d);
        chk(d, 32'h0000_0fff, "set all");
        wr(`SIM_OFF_ENABLE_CLR, 32'h0000_05a5);
        rd(`SIM_OFF_MASK_VIEW, d);
        chk(d, 32'h0000_0a5a, "clear some");
        wr(`SIM_OFF_ENABLE_SET, 32'h0);
        wr(`SIM_OFF_ENABLE_CLR, 32'h0);
        rd(`SIM_OFF_MASK_VIEW, d);
        chk(d, 32'h0000_0a5a, "zero writes");
        $display("test set clear done");
    endtask

    task automatic t_map();
        for (int i = 0; i < 12; i++) begin
            wr(`SIM_OFF_ENABLE_CLR, 32'hffff_ffff);
            wr(`SIM_OFF_ENABLE_SET, 32'h1 << i);
            rd(`SIM_OFF_MASK_VIEW, d);
            chk(d, 32'h1 << i, "mask bit");
            @(posedge clk) src <= sim_src_t'(12'h1 << pos[i]);
            if (i == 5 || i >= 8) begin
                @(posedge clk) src <= '0;
                // second load while the first word is unread
                if (i == 5) begin
                    @(posedge clk) src.rx_load <= 1'b1;
                    @(posedge clk) src <= '0;
                end
            end
            irq_after(1'b1, "irq on event");
            rd(`SIM_OFF_STATUS, d);
            chk(d, 32'h1 << i, "status bit");
            @(posedge clk) src <= '0;
            rx_word_read <= 1'b1;
            @(posedge clk) rx_word_read <= 1'b0;
            rd(`SIM_OFF_STATUS, d);
            chk(d, 32'h0, "status after read");
            irq_after(1'b0, "irq gone");
        end
        $display("test mapping done");
    endtask

    task automatic t_masked();
        wr(`SIM_OFF_ENABLE_CLR, 32'hffff_ffff);
        @(posedge clk) ce <= 1'b0;
        wr(`SIM_OFF_ENABLE_SET, 32'hffff_ffff);
        @(posedge clk) ce <= 1'b1;
        rd(`SIM_OFF_MASK_VIEW, d);
        chk(d, 32'h0, "write while frozen");
        @(posedge clk) src.compare_match_b <= 1'b1;
        @(posedge clk) src.compare_match_b <= 1'b0;
        irq_after(1'b0, "masked compare");
        rd(`SIM_OFF_STATUS, d);
        chk(d, 32'h0000_0200, "masked flag kept");
        wr(`SIM_OFF_ENABLE_SET, 32'h0000_0080);
        @(posedge clk) src.rx_counters_zero <= 1'b1;
        irq_after(1'b1, "buffer full irq");
        wr(`SIM_OFF_ENABLE_CLR, 32'h0000_0080);
        irq_after(1'b0, "buffer full disabled");
        @(posedge clk) src <= '0;
        $display("test masking done");
    endtask

    task automatic t_corner();
        // sync pulse in the very cycle of the status read survives the clear
        fork
            rd(`SIM_OFF_STATUS, d);
            begin
                @(posedge clk) src.tx_sync_seen <= 1'b1;
                @(posedge clk) src.tx_sync_seen <= 1'b0;
            end
        join
        chk(d, 32'h0, "status before late pulse");
        rd(`SIM_OFF_STATUS, d);
        chk(d, 32'h0000_0400, "pulse beside read kept");
        wr(`SIM_OFF_MASK_VIEW, 32'hffff_ffff);
        rd(`SIM_OFF_MASK_VIEW, d);
        chk(d, 32'h0, "mask view is read only");
        wr(`SIM_OFF_ENABLE_SET, 32'h0000_0c03);
        rd(`SIM_OFF_ENABLE_SET, d);
        chk(d, 32'h0, "enable set reads zero");
        @(posedge clk) srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        rd(`SIM_OFF_MASK_VIEW, d);
        chk(d, 32'h0, "mask after second reset");
        $display("test corner cases done");
    endtask

    initial begin
        bus_req = '0;
        src = '0;
        ce = 1'b1;
        rx_word_read = 1'b0;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_setclr();
        t_map();
        t_masked();
        t_corner();
        conclude();
    end
endmodule
